// [pkg/gcr_pkg.sv]
// package: constants for the chip global configuration register bank
package gcr_pkg;
  // register indices inside the configuration index space
  localparam logic [7:0] GCR_IDX_CONFIG_CONTROL = 8'h02;
  localparam logic [7:0] GCR_IDX_INDEX_ADDR_SEL = 8'h03;
  localparam logic [7:0] GCR_IDX_LOGICAL_DEV = 8'h07;
  localparam logic [7:0] GCR_IDX_DEVICE_IDENTITY = 8'h20;
  localparam logic [7:0] GCR_IDX_DEVICE_REVISION = 8'h21;
  localparam logic [7:0] GCR_IDX_FUNC_POWER = 8'h22;
  localparam logic [7:0] GCR_IDX_IPM_ENABLE = 8'h23;
  localparam logic [7:0] GCR_IDX_BANK_LAST = 8'h2F;
  // field positions and masks
  localparam int GCR_SOFT_RESET_BIT = 0;
  localparam int GCR_OUTSIDE_ACCESS_BIT = 7;
  localparam logic [7:0] GCR_INDEX_ADDR_MASK = 8'h83;
  localparam logic [7:0] GCR_FUNC_MASK = 8'h39;
  // reset values
  localparam logic [7:0] GCR_INDEX_ADDR_RST = 8'h03;
  localparam logic [7:0] GCR_LOGICAL_DEV_RST = 8'h00;
  localparam logic [7:0] GCR_FUNC_POWER_RST = 8'h00;
  localparam logic [7:0] GCR_IPM_ENABLE_RST = 8'h00;
  // run-mode general purpose index port codes and addresses
  localparam logic [1:0] GCR_GPI_CODE_EA = 2'h3;
  localparam logic [1:0] GCR_GPI_CODE_E2 = 2'h1;
  localparam logic [1:0] GCR_GPI_CODE_E0 = 2'h0;
  localparam logic [7:0] GCR_GPI_ADDR_EA = 8'hEA;
  localparam logic [7:0] GCR_GPI_ADDR_E2 = 8'hE2;
  localparam logic [7:0] GCR_GPI_ADDR_E0 = 8'hE0;
  // identity codes: arbitrary values
  localparam logic [7:0] GCR_IDENTITY_DEFAULT = 8'h5A;
  localparam logic [7:0] GCR_REVISION_DEFAULT = 8'h01;
endpackage

// [rtl/gcr_reset_sync.sv]
// two-flop release synchroniser for the active low reset
`timescale 1ns/100ps
`default_nettype none
module gcr_reset_sync (
  // clock and raw reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised reset
  output logic rst_sync_n
);
  // packed state of the synchroniser
  typedef struct packed {
    logic stage1;
    logic stage2;
  } gcr_rsync_s;
  gcr_rsync_s st_r;
  gcr_rsync_s st_nxt;

  // shift a one in after release
  always_comb begin
    st_nxt.stage1 = 1'b1;
    st_nxt.stage2 = st_r.stage1;
  end

  // assert at once, release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rst_sync_n = st_r.stage2;
endmodule
`default_nettype wire

// [rtl/gcr_gpi_decode.sv]
// run-mode general purpose index port address decoder
`timescale 1ns/100ps
`default_nettype none
module gcr_gpi_decode
  import gcr_pkg::*;
(
  // address select field
  input wire logic [1:0] addr_code,
  // decoded port address and its validity
  output logic [7:0] gpi_addr,
  output logic gpi_valid
);
  // map the two-bit code onto a port address
  always_comb begin
    gpi_addr = 8'h00;
    gpi_valid = 1'b1;
    case (addr_code)
      GCR_GPI_CODE_EA: gpi_addr = GCR_GPI_ADDR_EA;
      GCR_GPI_CODE_E2: gpi_addr = GCR_GPI_ADDR_E2;
      GCR_GPI_CODE_E0: gpi_addr = GCR_GPI_ADDR_E0;
      // reserved code: no port decoded at all
      default: gpi_valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/gcr_global_regs.sv]
// chip global configuration register bank behind the index and data ports
`timescale 1ns/100ps
`default_nettype none
module gcr_global_regs
  import gcr_pkg::*;
#(
  parameter logic [7:0] IDENTITY_CODE = GCR_IDENTITY_DEFAULT, // arbitrary value
  parameter logic [7:0] REVISION_CODE = GCR_REVISION_DEFAULT, // arbitrary value
  parameter int LOGICAL_DEV_COUNT = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration mode level from the mode entry logic
  input wire logic config_mode,
  // index port write strobe and data
  input wire logic index_wr,
  input wire logic [7:0] index_wdata,
  // data port strobes and write data
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] data_wdata,
  // read side
  output logic [7:0] index_rdata,
  output logic [7:0] data_rdata,
  output logic data_hit,
  // activate request from the per-device logic
  input wire logic activate_wr,
  input wire logic activate_val,
  // per-device activate outputs
  output logic [LOGICAL_DEV_COUNT-1:0] device_active,
  // soft reset pulse for the per-device registers
  output logic soft_reset,
  // selection and enables to the rest of the chip
  output logic [7:0] logical_device,
  output logic [7:0] gpi_port_addr,
  output logic gpi_port_valid,
  output logic outside_access_en,
  output logic [7:0] function_power,
  output logic [7:0] ipm_enable,
  output logic floppy_controller_pwr,
  output logic serial1_ipm
);
  // parameter sanity, refused at elaboration time
  // the device number register is eight bits wide, so 256 is the ceiling
  if (LOGICAL_DEV_COUNT < 1 || LOGICAL_DEV_COUNT > 256) begin : g_bad_count
    $error("gcr_global_regs: LOGICAL_DEV_COUNT out of range");
  end

  // synchronised reset used everywhere below
  logic rst_sync_n;

  gcr_reset_sync u_rsync (
    .clk(clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // all state of the bank
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] index_addr_sel;
    logic [7:0] logical_dev;
    logic [7:0] func_power;
    logic [7:0] ipm_en;
    logic soft_reset;
    logic [7:0] rdata;
    logic hit;
    logic [LOGICAL_DEV_COUNT-1:0] active;
  } gcr_state_s;

  gcr_state_s st_r;
  gcr_state_s st_nxt;

  // decode helpers
  logic in_bank; // index inside the global bank
  logic cfg_wr; // accepted write to the data port
  logic cfg_rd; // accepted read of the data port
  logic [7:0] rd_mux; // read value of the selected register
  logic ldn_in_range; // selected device exists

  // full eight-bit range compare, upper bits never dropped
  assign in_bank = (st_r.index <= GCR_IDX_BANK_LAST);
  // writes and reads count only in configuration mode
  assign cfg_wr = config_mode && data_wr && in_bank;
  assign cfg_rd = config_mode && data_rd && in_bank;
  // nine-bit compare so a count of 256 is not cut to zero
  assign ldn_in_range = ({1'b0, st_r.logical_dev} < 9'(LOGICAL_DEV_COUNT));

  // read multiplexer over the implemented registers
  always_comb begin
    rd_mux = 8'h00;
    case (st_r.index)
      GCR_IDX_INDEX_ADDR_SEL: rd_mux = st_r.index_addr_sel & GCR_INDEX_ADDR_MASK;
      GCR_IDX_LOGICAL_DEV: rd_mux = st_r.logical_dev;
      GCR_IDX_DEVICE_IDENTITY: rd_mux = IDENTITY_CODE;
      GCR_IDX_DEVICE_REVISION: rd_mux = REVISION_CODE;
      GCR_IDX_FUNC_POWER: rd_mux = st_r.func_power;
      GCR_IDX_IPM_ENABLE: rd_mux = st_r.ipm_en & GCR_FUNC_MASK;
      // config control is write only and reads zero with the reserved ones
      default: rd_mux = 8'h00;
    endcase
  end

  // next state of the whole bank
  always_comb begin
    st_nxt = st_r;
    // the request pulse lasts one cycle and falls by itself
    st_nxt.soft_reset = 1'b0;
    st_nxt.hit = cfg_rd;
    // index port: selects the register, data port follows
    if (index_wr && config_mode) begin
      st_nxt.index = index_wdata;
    end
    // register writes; reserved indices fall to default and are dropped
    if (cfg_wr) begin
      case (st_r.index)
        GCR_IDX_CONFIG_CONTROL: st_nxt.soft_reset = data_wdata[GCR_SOFT_RESET_BIT];
        GCR_IDX_INDEX_ADDR_SEL: st_nxt.index_addr_sel = data_wdata & GCR_INDEX_ADDR_MASK;
        GCR_IDX_LOGICAL_DEV: st_nxt.logical_dev = data_wdata;
        GCR_IDX_FUNC_POWER: st_nxt.func_power = data_wdata & GCR_FUNC_MASK;
        GCR_IDX_IPM_ENABLE: st_nxt.ipm_en = data_wdata & GCR_FUNC_MASK;
        // identity, revision and reserved indices ignore writes
        default: st_nxt.index = st_r.index;
      endcase
    end
    // activate lands on the selected device only
    if (activate_wr && config_mode && ldn_in_range) begin
      st_nxt.active[st_r.logical_dev[$clog2(LOGICAL_DEV_COUNT+1)-1:0]] = activate_val;
    end
    // soft reset: only registers with a soft reset value reload
    if (st_r.soft_reset) begin
      st_nxt.func_power = GCR_FUNC_POWER_RST;
      st_nxt.active = '0;
    end
    // read data captured into a flop
    if (cfg_rd) begin
      st_nxt.rdata = rd_mux;
    end
  end

  // state register, reset to documented defaults
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r.index <= 8'h00;
      st_r.index_addr_sel <= GCR_INDEX_ADDR_RST;
      st_r.logical_dev <= GCR_LOGICAL_DEV_RST;
      st_r.func_power <= GCR_FUNC_POWER_RST;
      st_r.ipm_en <= GCR_IPM_ENABLE_RST;
      st_r.soft_reset <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.hit <= 1'b0;
      st_r.active <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // run-mode index port address
  gcr_gpi_decode u_gpi (
    .addr_code(st_r.index_addr_sel[1:0]),
    .gpi_addr(gpi_port_addr),
    .gpi_valid(gpi_port_valid)
  );

  // outputs straight from state; index read back is zeroed outside configuration mode
  assign index_rdata = config_mode ? st_r.index : 8'h00;
  assign data_rdata = st_r.rdata;
  assign data_hit = st_r.hit;
  assign soft_reset = st_r.soft_reset;
  assign logical_device = st_r.logical_dev;
  assign device_active = st_r.active;
  assign outside_access_en = st_r.index_addr_sel[GCR_OUTSIDE_ACCESS_BIT];
  assign function_power = st_r.func_power;
  assign ipm_enable = st_r.ipm_en;
  assign floppy_controller_pwr = st_r.func_power[0];
  assign serial1_ipm = st_r.ipm_en[4];

  // checks next to the logic
  chk_mode_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!config_mode && data_rd) |=> !data_hit)
    else $error("data port answered outside configuration mode");
  chk_soft_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    soft_reset |=> !soft_reset)
    else $error("soft reset request did not self-clear");
  chk_soft_power: assert property (@(posedge clk) disable iff (!rst_sync_n)
    soft_reset |=> (function_power == 8'h00))
    else $error("power control not reloaded by soft reset");
  chk_soft_trigger: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_wr && st_r.index == GCR_IDX_CONFIG_CONTROL && data_wdata[0]) |=> soft_reset)
    else $error("soft reset write did not trigger");
  chk_id_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_rd && st_r.index == GCR_IDX_DEVICE_IDENTITY) |=> (data_rdata == IDENTITY_CODE))
    else $error("identity register read wrong");
  chk_rev_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_rd && st_r.index == GCR_IDX_DEVICE_REVISION) |=> (data_rdata == REVISION_CODE))
    else $error("revision register read wrong");
  chk_alias_free: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_rd && st_r.index > GCR_IDX_BANK_LAST) |=> !data_hit)
    else $error("index above bank answered");
  chk_ipm_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ipm_enable[7:6] == 2'b00) && (function_power[7:6] == 2'b00))
    else $error("reserved power bits set");
  chk_gpi_reserved: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r.index_addr_sel[1:0] == 2'b10) |-> !gpi_port_valid)
    else $error("reserved index code decoded an address");
  chk_ldn_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_wr && st_r.index == GCR_IDX_LOGICAL_DEV) |=> (logical_device == $past(data_wdata)))
    else $error("logical device not selected by write");

  // index port takes the written value in configuration mode
  chk_index_take: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (index_wr && config_mode) |=> (st_r.index == $past(index_wdata)))
    else $error("index port did not take written value");

  // index port ignores writes in run mode
  chk_index_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (index_wr && !config_mode) |=> $stable(st_r.index))
    else $error("index changed outside configuration mode");

  // data writes outside configuration mode leave power control alone
  chk_wr_outside: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!config_mode && data_wr && !soft_reset) |=> $stable(function_power))
    else $error("power control written outside configuration mode");

  // index read back follows the register only in configuration mode
  chk_index_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    config_mode |-> (index_rdata == st_r.index))
    else $error("index read back wrong");

  // index read back is zero in run mode
  chk_index_quiet: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !config_mode |-> (index_rdata == 8'h00))
    else $error("index visible outside configuration mode");

  // any data answer must have come from an accepted read
  chk_hit_cause: assert property (@(posedge clk) disable iff (!rst_sync_n)
    data_hit |-> $past(cfg_rd))
    else $error("data answer without accepted read");

  // every index inside the bank answers a read
  chk_hit_inbank: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_rd && st_r.index <= GCR_IDX_BANK_LAST) |=> data_hit)
    else $error("index inside bank did not answer");

  // read data holds between accepted reads
  chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cfg_rd |=> $stable(data_rdata))
    else $error("read data changed without a read");

  // the write only control register reads back zero
  chk_ctrl_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (config_mode && data_rd && st_r.index == GCR_IDX_CONFIG_CONTROL) |=> (data_rdata == 8'h00))
    else $error("control register read not zero");

  // reserved bits of the index address register never set
  chk_sel_reserved: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r.index_addr_sel[6:2] == 5'h00))
    else $error("reserved index address bits set");

  // only the four function bits of power control can be set
  chk_power_mask: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ((function_power & ~GCR_FUNC_MASK) == 8'h00))
    else $error("reserved power control bit set");

  // only the four function bits of power management can be set
  chk_ipm_mask: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ((ipm_enable & ~GCR_FUNC_MASK) == 8'h00))
    else $error("reserved power management bit set");

  // floppy power pin mirrors bit 0 of power control
  chk_fdc_power: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (floppy_controller_pwr == function_power[0]))
    else $error("floppy power out of step");

  // first serial port management follows bit 4
  chk_serial_ipm: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (serial1_ipm == ipm_enable[4]))
    else $error("serial management out of step");

  // outside access enable mirrors bit 7 of the index address register
  chk_outside_bit: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (outside_access_en == st_r.index_addr_sel[GCR_OUTSIDE_ACCESS_BIT]))
    else $error("outside access enable out of step");

  // code 11 decodes the default run-mode port
  chk_gpi_ea: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r.index_addr_sel[1:0] == GCR_GPI_CODE_EA) |-> (gpi_port_valid && gpi_port_addr == GCR_GPI_ADDR_EA))
    else $error("index code 11 decoded wrong");

  // code 01 decodes the second run-mode port
  chk_gpi_e2: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r.index_addr_sel[1:0] == GCR_GPI_CODE_E2) |-> (gpi_port_valid && gpi_port_addr == GCR_GPI_ADDR_E2))
    else $error("index code 01 decoded wrong");

  // code 00 decodes the third run-mode port
  chk_gpi_e0: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r.index_addr_sel[1:0] == GCR_GPI_CODE_E0) |-> (gpi_port_valid && gpi_port_addr == GCR_GPI_ADDR_E0))
    else $error("index code 00 decoded wrong");

  // no soft reset pulse without a control register write
  chk_soft_cause: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !(config_mode && data_wr && st_r.index == GCR_IDX_CONFIG_CONTROL) |=> !soft_reset)
    else $error("soft reset pulse without a write");

  // soft reset clears every activate bit
  chk_soft_active: assert property (@(posedge clk) disable iff (!rst_sync_n)
    soft_reset |=> (device_active == '0))
    else $error("activate bits not cleared by soft reset");

  // activate bits move only on an activate or a soft reset
  chk_act_quiet: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!activate_wr && !soft_reset) |=> $stable(device_active))
    else $error("activate bits changed without a request");

  // an activate for a missing device touches nothing
  chk_act_range: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (activate_wr && !ldn_in_range && !soft_reset) |=> $stable(device_active))
    else $error("activate reached a missing device");
endmodule
`default_nettype wire

// [dv/gcr_host_model.sv]
// host model: drives the index and data port strobes of the bank
`timescale 1ns/100ps
`default_nettype none
module gcr_host_model (
  // clock
  input wire logic clk,
  // strobes and data toward the bank
  output logic index_wr,
  output logic [7:0] index_wdata,
  output logic data_wr,
  output logic data_rd,
  output logic [7:0] data_wdata,
  // read answer
  input wire logic [7:0] data_rdata,
  input wire logic data_hit
);
  // idle strobes low; data lines start at a pattern, not a real value
  initial begin
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    index_wdata = 8'hA5;
    data_wdata = 8'h5A;
  end
  // index write first, data access after it
  task automatic put_idx(input logic [7:0] i);
    @(negedge clk);
    index_wr = 1'b1;
    index_wdata = i;
    @(negedge clk);
    index_wr = 1'b0;
    index_wdata = ~i; // released lines show no stale value
  endtask
  // one byte to the selected register
  task automatic put_dat(input logic [7:0] d);
    @(negedge clk);
    data_wr = 1'b1;
    data_wdata = d;
    @(negedge clk);
    data_wr = 1'b0;
    data_wdata = ~d;
  endtask
  // answer stands from the taking edge on, sampled half a cycle after it
  task automatic get_dat(output logic [7:0] d, output logic h);
    @(negedge clk);
    data_rd = 1'b1;
    @(negedge clk);
    data_rd = 1'b0;
    d = data_rdata;
    h = data_hit;
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// testbench: register bank checks through the index and data ports
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import gcr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, config_mode = 1'b1, activate_wr = 1'b0, activate_val = 1'b0;
  logic index_wr, data_wr, data_rd, data_hit, soft_reset, gpi_port_valid, outside_access_en;
  logic floppy_controller_pwr, serial1_ipm;
  logic [7:0] index_wdata, data_wdata, index_rdata, data_rdata, logical_device, gpi_port_addr;
  logic [7:0] function_power, ipm_enable, rd_v, gpi_exp [4];
  logic [8:0] device_active;
  logic rd_h;
  int fails = 0, total_checks = 0, cycles = 0;
  gcr_global_regs u_gcr_global_regs (.clk(clk), .rst_n(rst_n), .config_mode(config_mode),
    .index_wr(index_wr), .index_wdata(index_wdata), .data_wr(data_wr), .data_rd(data_rd),
    .data_wdata(data_wdata), .index_rdata(index_rdata), .data_rdata(data_rdata), .data_hit(data_hit),
    .activate_wr(activate_wr), .activate_val(activate_val), .device_active(device_active),
    .soft_reset(soft_reset), .logical_device(logical_device), .gpi_port_addr(gpi_port_addr),
    .gpi_port_valid(gpi_port_valid), .outside_access_en(outside_access_en),
    .function_power(function_power), .ipm_enable(ipm_enable),
    .floppy_controller_pwr(floppy_controller_pwr), .serial1_ipm(serial1_ipm));
  gcr_host_model u_gcr_host_model (.clk(clk), .index_wr(index_wr), .index_wdata(index_wdata),
    .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata), .data_rdata(data_rdata),
    .data_hit(data_hit));
  // 100 MHz clock
  always #5 clk = ~clk;
  // hang guard, far above the roughly two hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end
  // the one compare task; four-state match so unknowns fail
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    u_gcr_host_model.put_idx(i);
    u_gcr_host_model.put_dat(d);
  endtask
  // read with expected data and expected hit
  task automatic rreg(input logic [7:0] i, input logic [7:0] e, input logic h);
    u_gcr_host_model.put_idx(i);
    u_gcr_host_model.get_dat(rd_v, rd_h);
    chk("hit", {15'h0, h}, {15'h0, rd_h});
    if (h === 1'b1) chk("rdata", {8'h0, e}, {8'h0, rd_v});
  endtask
  task automatic activate(input logic v);
    @(negedge clk);
    activate_wr = 1'b1;
    activate_val = v;
    @(negedge clk);
    activate_wr = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    gpi_exp = '{GCR_GPI_ADDR_E0, GCR_GPI_ADDR_E2, 8'h00, GCR_GPI_ADDR_EA};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rreg(8'h03, 8'h03, 1'b1);
    rreg(8'h07, 8'h00, 1'b1);
    chk("index", 16'h0007, {8'h0, index_rdata});
    rreg(8'h22, 8'h00, 1'b1);
    rreg(8'h23, 8'h00, 1'b1);
    $display("test reset values done");
    // hard-wired codes must survive writes
    wreg(8'h20, 8'hFF);
    wreg(8'h21, 8'hFF);
    rreg(8'h20, GCR_IDENTITY_DEFAULT, 1'b1);
    rreg(8'h21, GCR_REVISION_DEFAULT, 1'b1);
    $display("test identity done");
    // reserved places inside the bank, then the edges of it
    foreach (gpi_exp[k]) wreg(8'h08 + 8'(k), 8'hFF);
    foreach (gpi_exp[k]) rreg(8'h08 + 8'(k), 8'h00, 1'b1);
    rreg(8'h00, 8'h00, 1'b1);
    rreg(8'h2F, 8'h00, 1'b1);
    rreg(8'h30, 8'h00, 1'b0);
    wreg(8'h83, 8'h00);
    rreg(8'h83, 8'h00, 1'b0);
    rreg(8'h03, 8'h03, 1'b1);
    $display("test decode done");
    // index address field, every code
    wreg(8'h03, 8'hFF);
    rreg(8'h03, 8'h83, 1'b1);
    chk("outside", 16'h1, {15'h0, outside_access_en});
    for (int c = 0; c < 4; c++) begin
      wreg(8'h03, 8'(c));
      chk("gpi addr", {8'h0, gpi_exp[c]}, {8'h0, gpi_port_addr});
      chk("gpi valid", {15'h0, c != 2}, {15'h0, gpi_port_valid});
    end
    chk("outside", 16'h0, {15'h0, outside_access_en});
    $display("test index address done");
    // per-function power bits
    wreg(8'h22, 8'hFF);
    rreg(8'h22, 8'h39, 1'b1);
    chk("fdc pwr", 16'h1, {15'h0, floppy_controller_pwr});
    wreg(8'h23, 8'hD6);
    rreg(8'h23, 8'h10, 1'b1);
    chk("ser ipm", 16'h1, {15'h0, serial1_ipm});
    wreg(8'h23, 8'h29);
    chk("ser ipm", 16'h0, {15'h0, serial1_ipm});
    chk("ipm", 16'h0029, {8'h0, ipm_enable});
    $display("test power done");
    // activate reaches only the selected device
    wreg(8'h07, 8'h03);
    activate(1'b1);
    chk("active", 16'h0008, {7'h0, device_active});
    wreg(8'h07, 8'h09);
    activate(1'b1);
    chk("active", 16'h0008, {7'h0, device_active});
    wreg(8'h07, 8'h08);
    activate(1'b1);
    chk("active", 16'h0108, {7'h0, device_active});
    $display("test activate done");
    // soft reset pulse, self clear, reload of its registers
    wreg(8'h02, 8'h01);
    chk("soft", 16'h1, {15'h0, soft_reset});
    @(negedge clk);
    chk("soft", 16'h0, {15'h0, soft_reset});
    chk("power", 16'h0, {8'h0, function_power});
    chk("active", 16'h0, {7'h0, device_active});
    chk("ipm", 16'h0029, {8'h0, ipm_enable});
    rreg(8'h02, 8'h00, 1'b1);
    $display("test soft reset done");
    // nothing answers outside configuration mode
    wreg(8'h22, 8'h01);
    config_mode = 1'b0;
    wreg(8'h22, 8'h08);
    rreg(8'h22, 8'h00, 1'b0);
    chk("index", 16'h0, {8'h0, index_rdata});
    config_mode = 1'b1;
    rreg(8'h22, 8'h01, 1'b1);
    $display("test config mode done");
    end_of_test();
  end
endmodule
`default_nettype wire
